// >>> shared/bbc_pkg.sv
/*
  shared constants of the baseband configuration bank: register offsets,
  field positions, mirror indices, recommended codes and timing counts.
  assumes a single 50 MHz core clock on both ends of the control port.
*/
`default_nettype none
package bbc_pkg;

  // -------------------------------------------------------------------
  // register offsets (byte addresses on the control port)
  // -------------------------------------------------------------------
  localparam logic [7:0] ACQ_AMP_THR_HIGH_OFS = 8'h20;
  localparam logic [7:0] ACQ_AMP_THR_LOW_OFS = 8'h24;
  localparam logic [7:0] ACQ_PHASE_THR_HIGH_OFS = 8'h28;
  localparam logic [7:0] ACQ_PHASE_THR_LOW_OFS = 8'h2c;
  localparam logic [7:0] CCA_AMP_THR_HIGH_OFS = 8'h30;
  localparam logic [7:0] CCA_AMP_THR_LOW_OFS = 8'h34;
  localparam logic [7:0] ENERGY_DETECT_THR_OFS = 8'h38;
  localparam logic [7:0] DELIM_SEARCH_TIMER_OFS = 8'h3c;
  localparam logic [7:0] CODE_RATE_1M_OFS = 8'h40;
  localparam logic [7:0] CODE_RATE_2M_OFS = 8'h44;
  localparam logic [7:0] CODE_RATE_5M5_OFS = 8'h48;
  localparam logic [7:0] CODE_RATE_11M_OFS = 8'h4c;
  localparam logic [7:0] TX_RATE_SELECT_OFS = 8'h50;
  localparam logic [7:0] LAST_OFS = TX_RATE_SELECT_OFS;

  // controller-own registers
  localparam logic [7:0] CTL_STATUS_OFS = 8'h80;
  localparam logic [7:0] CTL_CONTROL_OFS = 8'h84;

  // -------------------------------------------------------------------
  // mirror / bank indices: (offset - 0x20) / 4
  // -------------------------------------------------------------------
  localparam int REG_COUNT = 13;
  localparam logic [3:0] IDX_ACQ_AMP_HIGH = 4'h0;
  localparam logic [3:0] IDX_ACQ_AMP_LOW = 4'h1;
  localparam logic [3:0] IDX_ACQ_PHASE_HIGH = 4'h2;
  localparam logic [3:0] IDX_ACQ_PHASE_LOW = 4'h3;
  localparam logic [3:0] IDX_CCA_AMP_HIGH = 4'h4;
  localparam logic [3:0] IDX_CCA_AMP_LOW = 4'h5;
  localparam logic [3:0] IDX_ENERGY_THR = 4'h6;
  localparam logic [3:0] IDX_SEARCH_TIMER = 4'h7;
  localparam logic [3:0] IDX_CODE_1M = 4'h8;
  localparam logic [3:0] IDX_CODE_2M = 4'h9;
  localparam logic [3:0] IDX_CODE_5M5 = 4'ha;
  localparam logic [3:0] IDX_CODE_11M = 4'hb;
  localparam logic [3:0] IDX_TX_RATE = 4'hc;

  // -------------------------------------------------------------------
  // field positions and values
  // -------------------------------------------------------------------
  localparam int TX_HEADERLESS_BIT = 2;
  localparam logic [1:0] RATE_1M = 2'h0;
  localparam logic [1:0] RATE_2M = 2'h1;
  localparam logic [7:0] ENERGY_OFF_VALUE = 8'h3f;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int CTL_ENERGY_OFF_BIT = 0;
  localparam int CTL_SETTLED_BIT = 0;
  localparam int CTL_INIT_BUSY_BIT = 1;

  // recommended modulation codes, loaded by the controller after reset
  localparam logic [7:0] DEF_CODE_1M = 8'h0a;
  localparam logic [7:0] DEF_CODE_2M = 8'h14;
  localparam logic [7:0] DEF_CODE_5M5 = 8'h37;
  localparam logic [7:0] DEF_CODE_11M = 8'h6e;

  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int RATE_SETTLE_NS = 2000;
  localparam int RATE_SETTLE_CYC = (RATE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // true when an offset lands on a word of the bank
  function automatic logic bbc_in_bank(input logic [7:0] ofs);
    bbc_in_bank = (ofs >= ACQ_AMP_THR_HIGH_OFS) && (ofs <= LAST_OFS) && (ofs[1:0] == 2'h0);
  endfunction : bbc_in_bank

  // bank index of an offset
  function automatic logic [3:0] bbc_index(input logic [7:0] ofs);
    logic [7:0] rel;
    rel = ofs - ACQ_AMP_THR_HIGH_OFS;
    bbc_index = rel[5:2];
  endfunction : bbc_index

endpackage : bbc_pkg
`default_nettype wire

// >>> shared/bbc_cfg_if.sv
/*
  control port between the controller and the baseband configuration bank.
  assumes both ends share core_clk_i; no clocking block, no tristate.
*/
`default_nettype none
interface bbc_cfg_if;
  logic [7:0] addr; // register offset
  logic [7:0] wdata; // write byte
  logic wr; // one-cycle write strobe
  logic rd; // one-cycle read strobe
  logic [7:0] rdata; // read byte, valid the cycle after rd

  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport ctl (output addr, output wdata, output wr, output rd, input rdata);
endinterface : bbc_cfg_if
`default_nettype wire

// >>> verilog/bbc_dev.sv
/*
  device end: configuration bank of a spread-spectrum baseband processor,
  acquisition / clear-channel / energy-detect comparisons, delimiter search
  timer, receive signal-field match and transmit header code selection.
  assumes measurement inputs come from logic on core_clk_i (no synchronisers)
  and that the controller keeps the tx rate field at 00 in headerless mode.
*/
// Behaviour
// RULE_01 - acq amplitude threshold 15 bits, low byte 0-7
// RULE_02 - phase-variance threshold 16 bits, high and low
// RULE_03 - acquisition needs both threshold tests together
// RULE_04 - variance passes when not above threshold
// RULE_05 - separate 15-bit amplitude threshold for CCA dwell
// RULE_06 - amplitude quality passes when above threshold
// RULE_07 - energy detect when strength exceeds 6-bit threshold
// RULE_08 - controller writes 3Fh to disable energy detect
// RULE_09 - delimiter search bounded by 8-bit symbol timer
// RULE_10 - search timeout returns to acquisition
// RULE_11 - selected code sent, received field matched
// RULE_12 - controller programs 0Ah and 14h codes
// RULE_13 - controller programs 37h and 6Eh codes
// RULE_14 - 2-bit field selects tx rate and code
// RULE_15 - controller writes rate two microseconds early
// RULE_16 - headerless bit sends 2 Mbps, rate 00
// RULE_17 - tx select bits 7:3 stored, unused
// RULE_18 - received field valid only on code match
// RULE_19 - acq amplitude high byte gives bits 8-14
// RULE_20 - two-byte thresholds switch as consistent pairs
`default_nettype none
module bbc_dev (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  bbc_cfg_if.dev cfg,
  input wire logic [14:0] amplitude_quality_i,
  input wire logic [15:0] phase_variance_quality_i,
  input wire logic acq_dwell_i,
  input wire logic cca_dwell_i,
  input wire logic [5:0] signal_strength_reading_i,
  input wire logic symbol_tick_i,
  input wire logic delim_found_i,
  input wire logic rx_field_strobe_i,
  input wire logic [7:0] rx_field_i,
  input wire logic rx_done_i,
  output logic acquired_o,
  output logic searching_o,
  output logic cca_detect_o,
  output logic energy_detect_o,
  output logic delim_timeout_o,
  output logic rx_field_valid_o,
  output logic [1:0] rx_rate_o,
  output logic [7:0] tx_code_o,
  output logic [1:0] tx_rate_o,
  output logic tx_headerless_o
);
  import bbc_pkg::*;

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    RX_ACQ = 2'b00,
    RX_SEARCH = 2'b01,
    RX_HEADER = 2'b10
  } bbc_rx_type;

  typedef struct packed {
    logic [REG_COUNT-1:0][7:0] bank;
    logic [14:0] acq_amp_thr;
    logic [15:0] acq_phase_thr;
    logic [14:0] cca_amp_thr;
    logic [7:0] rdata;
    bbc_rx_type rx;
    logic [7:0] timer;
    logic acquired;
    logic search;
    logic cca_det;
    logic energy;
    logic timeout;
    logic fvalid;
    logic [1:0] rx_rate;
    logic [7:0] tx_code;
    logic [1:0] tx_rate;
    logic tx_hl;
  } bbc_dev_type;

  bbc_dev_type st_ff;
  bbc_dev_type nxt_st;

  // matches a received field against the four programmed codes
  function automatic logic [2:0] bbc_match(input logic [7:0] fld,
                                           input logic [REG_COUNT-1:0][7:0] bk);
    logic [2:0] res;
    res = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      if (fld == bk[IDX_CODE_1M + 4'(i)]) begin
        res = {1'b1, 2'(i)};
      end
    end
    bbc_match = res;
  endfunction : bbc_match

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    logic [3:0] idx;
    logic [2:0] hit;
    logic [7:0] txsel;
    logic amp_ok;
    logic phase_ok;
    idx = bbc_index(cfg.addr);
    hit = bbc_match(rx_field_i, st_ff.bank);
    txsel = st_ff.bank[IDX_TX_RATE];
    amp_ok = 1'b0;
    phase_ok = 1'b0;
    nxt_st = st_ff;
    nxt_st.rdata = RESET_BYTE;
    nxt_st.timeout = 1'b0;

    // register write; all eight bits stored, unused ones too
    if (cfg.wr && bbc_in_bank(cfg.addr)) begin
      nxt_st.bank[idx] = cfg.wdata; // RULE_17
      // low-byte write commits the pair with the held high byte
      if (idx == IDX_ACQ_AMP_LOW) begin
        nxt_st.acq_amp_thr = {st_ff.bank[IDX_ACQ_AMP_HIGH][6:0],
                              cfg.wdata}; // RULE_01 RULE_19 RULE_20
      end else if (idx == IDX_ACQ_PHASE_LOW) begin
        nxt_st.acq_phase_thr = {st_ff.bank[IDX_ACQ_PHASE_HIGH], cfg.wdata}; // RULE_02 RULE_20
      end else if (idx == IDX_CCA_AMP_LOW) begin
        nxt_st.cca_amp_thr = {st_ff.bank[IDX_CCA_AMP_HIGH][6:0], cfg.wdata}; // RULE_05 RULE_20
      end
    end

    // register read, zero for unmapped offsets
    if (cfg.rd && bbc_in_bank(cfg.addr)) begin
      nxt_st.rdata = st_ff.bank[idx];
    end

    // energy detect follows the strength reading every cycle
    nxt_st.energy = signal_strength_reading_i >
                    st_ff.bank[IDX_ENERGY_THR][5:0]; // RULE_07 RULE_08

    // clear-channel amplitude test on the cca dwell
    if (cca_dwell_i) begin
      nxt_st.cca_det = amplitude_quality_i > st_ff.cca_amp_thr; // RULE_05 RULE_06
    end

    // receive sequence
    case (st_ff.rx)
      RX_ACQ: begin
        nxt_st.acquired = 1'b0;
        amp_ok = amplitude_quality_i > st_ff.acq_amp_thr; // RULE_06
        phase_ok = phase_variance_quality_i <= st_ff.acq_phase_thr; // RULE_04
        if (acq_dwell_i && amp_ok && phase_ok) begin // RULE_03
          nxt_st.acquired = 1'b1;
          nxt_st.fvalid = 1'b0;
          nxt_st.rx = RX_SEARCH;
          nxt_st.timer = st_ff.bank[IDX_SEARCH_TIMER]; // RULE_09
        end
      end
      RX_SEARCH: begin
        if (delim_found_i) begin
          nxt_st.rx = RX_HEADER;
        end else if (symbol_tick_i) begin
          if (st_ff.timer == 8'h00) begin
            nxt_st.timeout = 1'b1; // RULE_10
            nxt_st.acquired = 1'b0;
            nxt_st.rx = RX_ACQ;
          end else begin
            nxt_st.timer = st_ff.timer - 8'h01; // RULE_09
          end
        end
      end
      RX_HEADER: begin
        if (rx_field_strobe_i) begin
          nxt_st.fvalid = hit[2]; // RULE_11 RULE_18
          nxt_st.rx_rate = hit[1:0];
        end
        if (rx_done_i) begin
          nxt_st.acquired = 1'b0;
          nxt_st.rx = RX_ACQ;
        end
      end
      default: begin
        nxt_st.rx = RX_ACQ;
      end
    endcase

    // transmit header code, rate and headerless mode
    nxt_st.tx_code = st_ff.bank[IDX_CODE_1M + {2'h0, txsel[1:0]}]; // RULE_11 RULE_14
    nxt_st.tx_hl = txsel[TX_HEADERLESS_BIT]; // RULE_16
    nxt_st.tx_rate = txsel[TX_HEADERLESS_BIT] ? RATE_2M : txsel[1:0]; // RULE_14 RULE_16

    // search flag registered beside the state so the output is a flop
    nxt_st.search = (nxt_st.rx == RX_SEARCH);
  end

  // -------------------------------------------------------------------
  // state register
  // -------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign cfg.rdata = st_ff.rdata;
  assign acquired_o = st_ff.acquired;
  assign searching_o = st_ff.search;
  assign cca_detect_o = st_ff.cca_det;
  assign energy_detect_o = st_ff.energy;
  assign delim_timeout_o = st_ff.timeout;
  assign rx_field_valid_o = st_ff.fvalid;
  assign rx_rate_o = st_ff.rx_rate;
  assign tx_code_o = st_ff.tx_code;
  assign tx_rate_o = st_ff.tx_rate;
  assign tx_headerless_o = st_ff.tx_hl;

endmodule : bbc_dev
`default_nettype wire

// >>> verilog/bbc_ctl.sv
/*
  controller end: takes register orders from software on a plain port,
  forwards writes to the bank, answers reads from a mirror in one cycle,
  loads the recommended codes after reset and tracks the rate settle time.
  assumes software waits for init to finish before writing the bank.
*/
`default_nettype none
module bbc_ctl (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  bbc_cfg_if.ctl cfg,
  input wire logic [7:0] sw_addr_i,
  input wire logic [7:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [7:0] sw_rdata_o
);
  import bbc_pkg::*;

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [REG_COUNT-1:0][7:0] mirror;
    logic [2:0] init_step;
    logic [7:0] settle;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic [7:0] rdata;
  } bbc_ctl_type;

  bbc_ctl_type st_ff;
  bbc_ctl_type nxt_st;

  always_comb begin
    logic [7:0] ofs;
    logic [7:0] val;
    logic go;
    ofs = sw_addr_i;
    val = sw_wdata_i;
    go = 1'b0;
    nxt_st = st_ff;
    nxt_st.wr = 1'b0;
    nxt_st.rdata = RESET_BYTE;
    if (st_ff.settle != 8'h00) begin
      nxt_st.settle = st_ff.settle - 8'h01;
    end

    // after reset: load the four recommended codes, one per cycle
    if (st_ff.init_step != 3'h4) begin
      ofs = CODE_RATE_1M_OFS + {3'h0, st_ff.init_step, 2'h0};
      case (st_ff.init_step)
        3'h0: val = DEF_CODE_1M; // RULE_12
        3'h1: val = DEF_CODE_2M; // RULE_12
        3'h2: val = DEF_CODE_5M5; // RULE_13
        default: val = DEF_CODE_11M; // RULE_13
      endcase
      go = 1'b1;
      nxt_st.init_step = st_ff.init_step + 3'h1;
    end else if (sw_wr_i) begin
      if (ofs == CTL_CONTROL_OFS) begin
        // energy-detect disable writes all ones to the threshold
        if (sw_wdata_i[CTL_ENERGY_OFF_BIT]) begin
          ofs = ENERGY_DETECT_THR_OFS;
          val = ENERGY_OFF_VALUE; // RULE_08
          go = 1'b1;
        end
      end else if (bbc_in_bank(ofs)) begin
        go = 1'b1;
        if (bbc_index(ofs) == IDX_TX_RATE) begin
          if (val[TX_HEADERLESS_BIT]) begin
            val[1:0] = RATE_1M; // RULE_16
          end
          nxt_st.settle = 8'(RATE_SETTLE_CYC); // RULE_15
        end
      end
    end

    // forward the write and keep the mirror in step
    if (go) begin
      nxt_st.mirror[bbc_index(ofs)] = val;
      nxt_st.addr = ofs;
      nxt_st.wdata = val;
      nxt_st.wr = 1'b1;
    end

    // reads answered from the mirror and own status
    if (sw_rd_i) begin
      if (sw_addr_i == CTL_STATUS_OFS) begin
        nxt_st.rdata[CTL_SETTLED_BIT] = st_ff.settle == 8'h00; // RULE_15
        nxt_st.rdata[CTL_INIT_BUSY_BIT] = st_ff.init_step != 3'h4;
      end else if (bbc_in_bank(sw_addr_i)) begin
        nxt_st.rdata = st_ff.mirror[bbc_index(sw_addr_i)];
      end
    end
  end

  // -------------------------------------------------------------------
  // state register
  // -------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // link reads are not used: the mirror answers software
  assign cfg.addr = st_ff.addr;
  assign cfg.wdata = st_ff.wdata;
  assign cfg.wr = st_ff.wr;
  assign cfg.rd = 1'b0;
  assign sw_rdata_o = st_ff.rdata;

endmodule : bbc_ctl
`default_nettype wire

// >>> test/bbc_assertions.sv
/*
  link checker for the control port joining controller and device.
  assumes one clock and a synchronous active-low reset; signals come in plain.
*/
`default_nettype none
module bbc_assertions
  import bbc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // helper logic
  // ------------------------------------------------------------
  logic [3:0] age_ff; // edges since reset release, saturating

  // age counter, keeps the init window visible
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      age_ff <= 4'h0;
    end else if (age_ff != 4'hf) begin
      age_ff <= age_ff + 4'h1;
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // ------------------------------------------------------------
  // link properties
  // ------------------------------------------------------------
  init_low_codes_a: assert property (
    $rose(rst_n_i) |-> ##[0:2] (wr_i && addr_i == CODE_RATE_1M_OFS && wdata_i == DEF_CODE_1M)
    ##1 (wr_i && addr_i == CODE_RATE_2M_OFS && wdata_i == DEF_CODE_2M))
    else $error("low-rate codes not loaded after reset");
  init_high_codes_a: assert property (
    (wr_i && addr_i == CODE_RATE_2M_OFS && age_ff < 4'h8) |=>
    (wr_i && addr_i == CODE_RATE_5M5_OFS && wdata_i == DEF_CODE_5M5)
    ##1 (wr_i && addr_i == CODE_RATE_11M_OFS && wdata_i == DEF_CODE_11M) ##1 !wr_i)
    else $error("high-rate codes not loaded after reset");
  init_only_codes_a: assert property (
    (wr_i && age_ff < 4'h8) |-> (addr_i[7:4] == 4'h4 && addr_i[1:0] == 2'h0))
    else $error("stray link write during init");
  headerless_rate_a: assert property (
    (wr_i && addr_i == TX_RATE_SELECT_OFS && wdata_i[TX_HEADERLESS_BIT])
    |-> wdata_i[1:0] == 2'h0)
    else $error("headerless write with nonzero rate");
  wr_in_bank_a: assert property (
    wr_i |-> (addr_i >= ACQ_AMP_THR_HIGH_OFS && addr_i <= LAST_OFS && addr_i[1:0] == 2'h0))
    else $error("link write outside the bank");
  link_no_read_a: assert property (rd_i == 1'h0)
    else $error("controller drove a link read");
  strobe_excl_a: assert property (!(wr_i && rd_i))
    else $error("link read and write together");
  rdata_idle_a: assert property (!$past(rd_i) |-> rdata_i == 8'h00)
    else $error("link read data without a read");
endmodule : bbc_assertions
`default_nettype wire

// >>> test/tb_baseband_acq_header_config.sv
/*
  bench: controller and device joined on the link, driven on the software
  port and measurement inputs. assumes the shared map and a 50 MHz clock.
*/
`default_nettype none
module tb_baseband_acq_header_config import bbc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [7:0] sw_addr_i, sw_wdata_i, sw_rdata_o, rx_field_i, tx_code_o, d, fld;
  logic sw_wr_i, sw_rd_i, acq_dwell_i, cca_dwell_i, symbol_tick_i, delim_found_i;
  logic rx_field_strobe_i, rx_done_i, acquired_o, searching_o, cca_detect_o, hit;
  logic energy_detect_o, delim_timeout_o, rx_field_valid_o, tx_headerless_o, e;
  logic [5:0] signal_strength_reading_i;
  logic [14:0] amplitude_quality_i, ath, cth, amp;
  logic [15:0] phase_variance_quality_i, pth, pvar, r;
  logic [1:0] rx_rate_o, tx_rate_o;
  logic [2:0] m;
  logic [15:0] seed = 16'h0050;
  logic [7:0] codes [4];
  int miscompares = 0;
  int num_checks = 0;
  int cnt;

  // ------------------------------------------------------------
  // clock and design
  // ------------------------------------------------------------
  always #10 core_clk_i = ~core_clk_i;

  bbc_cfg_if i_bbc_cfg_if ();
  bbc_dev i_bbc_dev (.core_clk_i, .rst_n_i, .cfg(i_bbc_cfg_if), .amplitude_quality_i,
    .phase_variance_quality_i, .acq_dwell_i, .cca_dwell_i, .signal_strength_reading_i,
    .symbol_tick_i, .delim_found_i, .rx_field_strobe_i, .rx_field_i, .rx_done_i,
    .acquired_o, .searching_o, .cca_detect_o, .energy_detect_o, .delim_timeout_o,
    .rx_field_valid_o, .rx_rate_o, .tx_code_o, .tx_rate_o, .tx_headerless_o);
  bbc_ctl i_bbc_ctl (.core_clk_i, .rst_n_i, .cfg(i_bbc_cfg_if), .sw_addr_i, .sw_wdata_i,
    .sw_wr_i, .sw_rd_i, .sw_rdata_o);
  bbc_assertions i_bbc_assertions (.core_clk_i, .rst_n_i, .addr_i(i_bbc_cfg_if.addr),
    .wdata_i(i_bbc_cfg_if.wdata), .wr_i(i_bbc_cfg_if.wr), .rd_i(i_bbc_cfg_if.rd),
    .rdata_i(i_bbc_cfg_if.rdata));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // shift register source of stimulus
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : rnd
  // expected match: valid bit and lowest matching index
  function automatic logic [2:0] f_match(input logic [7:0] f);
    f_match = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      if (codes[i] == f) f_match = {1'h1, 2'(i)};
    end
  endfunction : f_match
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8
  task chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1
  task summarize();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  task cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : cyc
  task sw_write(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk_i);
    sw_addr_i <= a;
    sw_wdata_i <= v;
    sw_wr_i <= 1'h1;
    @(posedge core_clk_i);
    sw_wr_i <= 1'h0;
  endtask : sw_write
  task sw_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    sw_addr_i <= a;
    sw_rd_i <= 1'h1;
    @(posedge core_clk_i);
    sw_rd_i <= 1'h0;
    #1 chk8(sw_rdata_o, exp);
  endtask : sw_read
  // one-cycle strobe: 0 dwell, 1 tick, 2 found, 3 field, 4 done
  task pulse(input int k);
    @(posedge core_clk_i);
    {acq_dwell_i, cca_dwell_i, symbol_tick_i} <= {k == 0, k == 0, k == 1};
    {delim_found_i, rx_field_strobe_i, rx_done_i} <= {k == 2, k == 3, k == 4};
    @(posedge core_clk_i);
    {acq_dwell_i, cca_dwell_i, symbol_tick_i, delim_found_i} <= 4'h0;
    {rx_field_strobe_i, rx_done_i} <= 2'h0;
    #1;
  endtask : pulse

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {sw_addr_i, sw_wdata_i, sw_wr_i, sw_rd_i, rx_field_i} = 26'h000_0000;
    {amplitude_quality_i, phase_variance_quality_i} = 31'h0000_0000;
    signal_strength_reading_i = 6'h00;
    {acq_dwell_i, cca_dwell_i, symbol_tick_i, delim_found_i, rx_field_strobe_i} = 5'h00;
    rx_done_i = 1'h0;
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'h1;
    cyc(10);
    // recommended codes after reset, unmapped and unaligned places
    sw_read(CODE_RATE_1M_OFS, DEF_CODE_1M);
    sw_read(CODE_RATE_2M_OFS, DEF_CODE_2M);
    sw_read(CODE_RATE_5M5_OFS, DEF_CODE_5M5);
    sw_read(CODE_RATE_11M_OFS, DEF_CODE_11M);
    sw_read(DELIM_SEARCH_TIMER_OFS, RESET_BYTE);
    chk8(tx_code_o, DEF_CODE_1M);
    sw_write(8'h41, 8'h5a);
    sw_read(8'h41, 8'h00);
    sw_read(8'h54, 8'h00);
    // random codes, the last one duplicating the second
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      codes[i] = (i == 3) ? codes[1] : r[7:0];
      sw_write(CODE_RATE_1M_OFS + 8'(4 * i), codes[i]);
    end
    // every rate select, upper bits random
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      d = {r[4:0], 1'h0, 2'(i)};
      sw_write(TX_RATE_SELECT_OFS, d);
      cyc(4);
      chk8({6'h00, tx_rate_o}, {6'h00, d[1:0]});
      chk8(tx_code_o, codes[i]);
      chk1(tx_headerless_o, 1'h0);
      sw_read(TX_RATE_SELECT_OFS, d);
    end
    sw_read(CTL_STATUS_OFS, 8'h00);
    cyc(100);
    sw_read(CTL_STATUS_OFS, 8'h01);
    sw_write(TX_RATE_SELECT_OFS, 8'h07);
    cyc(4);
    chk1(tx_headerless_o, 1'h1);
    chk8({6'h00, tx_rate_o}, 8'h01);
    // energy detect: disable value, equality corner, random
    for (int k = 0; k < 10; k++) begin
      r = rnd();
      if (k == 0) sw_write(CTL_CONTROL_OFS, 8'h01);
      else sw_write(ENERGY_DETECT_THR_OFS, r[7:0]);
      d = (k == 0) ? ENERGY_OFF_VALUE : r[7:0];
      signal_strength_reading_i <= (k == 0) ? 6'h3f : (k == 2) ? d[5:0] : r[13:8];
      cyc(4);
      chk1(energy_detect_o, signal_strength_reading_i > d[5:0]);
    end
    // acquisition, clear channel and received field, with a pending high byte
    for (int k = 0; k < 16; k++) begin
      r = rnd();
      ath = r[14:0];
      pth = rnd();
      r = rnd();
      cth = r[14:0];
      sw_write(ACQ_AMP_THR_HIGH_OFS, {pth[0], ath[14:8]});
      sw_write(ACQ_AMP_THR_LOW_OFS, ath[7:0]);
      sw_write(ACQ_PHASE_THR_HIGH_OFS, pth[15:8]);
      sw_write(ACQ_PHASE_THR_LOW_OFS, pth[7:0]);
      sw_write(CCA_AMP_THR_HIGH_OFS, {r[15], cth[14:8]});
      sw_write(CCA_AMP_THR_LOW_OFS, cth[7:0]);
      sw_write(ACQ_AMP_THR_HIGH_OFS, ~{1'h0, ath[14:8]});
      r = rnd();
      if (k == 0) r[5:0] = 6'h25;
      amp = r[2] ? ath + 15'(r[0]) : cth + 15'(r[3]);
      pvar = r[5] ? pth + 16'(r[4]) : ~pth;
      amplitude_quality_i <= amp;
      phase_variance_quality_i <= pvar;
      cyc(4);
      pulse(0);
      e = (amp > ath) && (pvar <= pth);
      chk1(acquired_o, e);
      chk1(searching_o, e);
      chk1(cca_detect_o, amp > cth);
      if (e) begin
        pulse(2);
        fld = r[6] ? codes[r[8:7]] : r[15:8];
        @(posedge core_clk_i) rx_field_i <= fld;
        pulse(3);
        m = f_match(fld);
        chk1(rx_field_valid_o, m[2]);
        if (m[2]) chk8({6'h00, rx_rate_o}, {6'h00, m[1:0]});
        pulse(4);
      end
    end
    // delimiter search timeout: zero, small and random counts
    sw_write(ACQ_AMP_THR_HIGH_OFS, 8'h00);
    sw_write(ACQ_AMP_THR_LOW_OFS, 8'h00);
    sw_write(ACQ_PHASE_THR_HIGH_OFS, 8'hff);
    sw_write(ACQ_PHASE_THR_LOW_OFS, 8'hff);
    amplitude_quality_i <= 15'h0001;
    phase_variance_quality_i <= 16'h0000;
    for (int t = 0; t < 3; t++) begin
      r = rnd();
      d = (t == 0) ? 8'h00 : (t == 1) ? 8'h03 : {5'h00, r[2:0]};
      sw_write(DELIM_SEARCH_TIMER_OFS, d);
      cyc(4);
      pulse(0);
      cnt = 0;
      hit = 1'h0;
      while (!hit && cnt < 40) begin
        pulse(1);
        cnt++;
        hit = (delim_timeout_o === 1'h1);
      end
      if (!hit) begin
        miscompares++;
        summarize();
      end
      chk8(8'(cnt), d + 8'h01);
      cyc(1);
      chk1(acquired_o, 1'h0);
      chk1(searching_o, 1'h0);
    end
    summarize();
  end
endmodule : tb_baseband_acq_header_config
`default_nettype wire
